// ### fetch_model.sv
/*
 * fetch-side model: asks for one interrupt vector per toggle of go,
 * holds the request until the answer, and keeps that answer.
 * assumes the vector map answers one rising clock edge after it takes the request.
 */
`timescale 1ns/100ps
module fetch_model (
    // clock
    input wire logic clk,
    // bench control
    input wire logic go,
    // vector map side
    input wire vector_map_pkg::fetch_type fetch,
    input wire logic [33:0] taken,
    output logic vec_req,
    // captured answer
    output vector_map_pkg::fetch_type last_q,
    output logic [33:0] last_taken_q,
    output int n_got_q
);
    import vector_map_pkg::*;
    logic go_q = 1'b0;
    initial
    begin
        vec_req = 1'b0;
        last_q = '0;
        last_taken_q = '0;
        n_got_q = 0;
    end
    // request held until an interrupt answer is sampled
    always @(posedge clk)
    begin
        if (go !== go_q)
        begin
            go_q <= go;
            vec_req <= #1 1'b1;
        end
        else if (vec_req && fetch.valid === 1'b1 && fetch.is_reset === 1'b0)
        begin
            vec_req <= #1 1'b0;
            last_q <= fetch;
            last_taken_q <= taken;
            n_got_q <= n_got_q + 1;
        end
    end
endmodule

// ### irq_pick.sv
/*
 * lowest-index pending request picker.
 * assumes requests are levels synchronous to the caller's clock.
 */
`timescale 1ns/100ps
module irq_pick #(
    parameter int WIDTH = 34
) (
    // requests, bit 0 wins
    input wire logic [WIDTH-1:0] req,
    // result
    output logic found,
    output logic [5:0] index
);
    always_comb
    begin
        found = 1'b0;
        index = 6'h00;
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = 6'(i);
            end
        end
    end
endmodule

// ### reset_interrupt_vector_map.sv
/*
 * reset and interrupt vector map: presents the reset vector after any
 * reset, then on each fetch request the vector of the lowest-numbered
 * pending source, placed by the boot-reset fuse and vector-select bit.
 * assumes the fetch logic, fuses and control bit are synchronous to REF_CLK.
 */
// Operation
// (R1) reset vector is vector 1, address zero, shared by every reset cause
// (R2) programmed boot-reset fuse (0) moves the reset vector to boot start
// (R3) vector-select set adds boot section start to every interrupt address
// (R4) interrupt vectors start at 2, or boot start plus 2, fuse aside
// (R5) external requests 0, 1, 2 map to vectors 2, 3, 4
// (R6) pin change 0..3 map to vectors 5..8, watchdog to vector 9
// (R7) timer 2 compare A, compare B, overflow at vectors 10..12
// (R8) timer 1 capture, compare A, compare B, overflow at vectors 13..16
// (R9) timer 0 compare A, compare B, overflow at vectors 17..19
// (R10) serial peripheral transfer complete at vector 20
// (R11) first serial port receive, data empty, transmit at vectors 21..23
// (R12) comparator, converter, eeprom, two-wire, store ready at vectors 24..28
// (R13) second serial port receive, data empty, transmit at vectors 29..31
// (R14) timer 3 vectors 32..35 exist only on the largest member
// (R15) vector-select 0 places vectors at flash start, 1 at boot section
// (R16) address is placement base plus twice vector number minus one
`timescale 1ns/100ps
module reset_interrupt_vector_map #(
    parameter bit HAS_TIMER3 = 1'b1
) (
    // clock and control
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // placement settings
    input wire vector_map_pkg::placement_type PLACEMENT,
    // interrupt sources
    input wire vector_map_pkg::irq_src_type IRQ_SRC,
    // fetch side
    input wire logic VEC_REQ,
    output vector_map_pkg::fetch_type FETCH,
    output logic [33:0] IRQ_TAKEN,
    output logic IRQ_PENDING
);
    import vector_map_pkg::*;

    logic [NUM_IRQ-1:0] req_vec;
    logic [NUM_IRQ-1:0] req_gated;
    logic found;
    logic [5:0] pick_index;
    logic [5:0] vno_d;
    logic [16:0] addr_d;
    logic take_irq;
    logic boot_issue;
    state_type state_q;
    state_type state_d;
    fetch_type fetch_q;
    fetch_type fetch_d;
    logic [NUM_IRQ-1:0] taken_q;
    logic [NUM_IRQ-1:0] taken_d;
    logic pend_q;
    logic fuse_q;
    logic [16:0] boot_q;

    // source to vector order
    assign req_vec[2:0] = {IRQ_SRC.ext_irq_two, IRQ_SRC.ext_irq_one,
        IRQ_SRC.ext_irq_zero}; // see (R5)
    assign req_vec[7:3] = {IRQ_SRC.watchdog_timeout_req, IRQ_SRC.pin_change_req_three,
        IRQ_SRC.pin_change_req_two, IRQ_SRC.pin_change_req_one,
        IRQ_SRC.pin_change_req_zero}; // see (R6)
    assign req_vec[10:8] = {IRQ_SRC.tmr2_ovf, IRQ_SRC.tmr2_cmp_b,
        IRQ_SRC.tmr2_cmp_a}; // see (R7)
    assign req_vec[14:11] = {IRQ_SRC.tmr1_ovf, IRQ_SRC.tmr1_cmp_b, IRQ_SRC.tmr1_cmp_a,
        IRQ_SRC.tmr1_capture}; // see (R8)
    assign req_vec[17:15] = {IRQ_SRC.tmr0_ovf, IRQ_SRC.tmr0_cmp_b,
        IRQ_SRC.tmr0_cmp_a}; // see (R9)
    assign req_vec[18] = IRQ_SRC.spi_done; // see (R10)
    assign req_vec[21:19] = {IRQ_SRC.ser0_tx_done, IRQ_SRC.ser0_tx_empty,
        IRQ_SRC.ser0_rx_done}; // see (R11)
    assign req_vec[26:22] = {IRQ_SRC.program_store_ready_req, IRQ_SRC.two_wire_req,
        IRQ_SRC.eeprom_ready_req, IRQ_SRC.conv_done, IRQ_SRC.comparator}; // see (R12)
    assign req_vec[29:27] = {IRQ_SRC.ser1_tx_done, IRQ_SRC.ser1_tx_empty,
        IRQ_SRC.ser1_rx_done}; // see (R13)
    assign req_vec[33:30] = {IRQ_SRC.tmr3_ovf, IRQ_SRC.tmr3_cmp_b, IRQ_SRC.tmr3_cmp_a,
        IRQ_SRC.tmr3_capture};

    // timer 3 lines vanish on smaller members
    assign req_gated[TIMER3_FIRST_BIT-1:0] = req_vec[TIMER3_FIRST_BIT-1:0];
    assign req_gated[NUM_IRQ-1:TIMER3_FIRST_BIT] = HAS_TIMER3 ?
        req_vec[NUM_IRQ-1:TIMER3_FIRST_BIT] : 4'h0; // see (R14)

    irq_pick #(
        .WIDTH(NUM_IRQ)
    ) u_pick (
        .req(req_gated),
        .found(found),
        .index(pick_index)
    );

    // selection of what goes out next
    assign boot_issue = (state_q == ST_BOOT); // see (R1)
    assign take_irq = (state_q == ST_IDLE) && VEC_REQ && found;
    assign vno_d = boot_issue ? RESET_VECTOR_NO
                              : 6'(pick_index + FIRST_IRQ_VECTOR_NO); // see (R4)

    // placement and stride
    vector_addr_calc u_calc (
        .is_reset(boot_issue),
        .vector_no(vno_d),
        .place(PLACEMENT),
        .addr(addr_d)
    ); // see (R2) see (R3) see (R15) see (R16)

    assign fetch_d.valid = boot_issue || take_irq;
    assign fetch_d.is_reset = boot_issue;
    assign fetch_d.vector_no = fetch_d.valid ? vno_d : 6'h00;
    assign fetch_d.addr = fetch_d.valid ? addr_d : 17'h0_0000;
    assign taken_d = take_irq ? (NUM_IRQ'(1) << pick_index) : '0;

    always_comb
    begin
        case (state_q)
            ST_BOOT:
                state_d = ST_IDLE;
            ST_IDLE:
                state_d = take_irq ? ST_ISSUE : ST_IDLE;
            ST_ISSUE:
                state_d = ST_IDLE;
            default:
                state_d = ST_BOOT;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_q <= ST_BOOT;
            fetch_q <= '0;
            taken_q <= '0;
            pend_q <= 1'b0;
            fuse_q <= FUSE_RESET_VALUE;
            boot_q <= BOOT_RESET_VALUE;
        end
        else if (CE)
        begin
            state_q <= state_d;
            fetch_q <= fetch_d;
            taken_q <= taken_d;
            pend_q <= found;
            if (boot_issue)
            begin
                fuse_q <= PLACEMENT.boot_reset_fuse;
                boot_q <= PLACEMENT.boot_start;
            end
        end
    end

    assign FETCH = fetch_q;
    assign IRQ_TAKEN = taken_q;
    assign IRQ_PENDING = pend_q;

    // checks
    a_reset_vector_app: // see (R1)
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.valid && fetch_q.is_reset && fuse_q
        |-> fetch_q.addr == APP_BASE_ADDR && fetch_q.vector_no == RESET_VECTOR_NO)
    else $error("reset vector not at address zero");

    a_boot_first_fetch: // see (R1)
    assert property (@(posedge REF_CLK) disable iff (RST)
        state_q == ST_BOOT && CE
        |=> fetch_q.valid && fetch_q.is_reset && state_q == ST_IDLE)
    else $error("reset vector not issued first");

    a_reset_vector_boot: // see (R2)
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.valid && fetch_q.is_reset && !fuse_q
        |-> fetch_q.addr == boot_q)
    else $error("programmed fuse did not move reset vector");

    a_select_moves_irq: // see (R3)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && PLACEMENT.vector_select_bit
        |=> fetch_q.addr == 17'($past(PLACEMENT.boot_start)
            + {10'h000, fetch_q.vector_no - 6'h01, 1'b0}))
    else $error("interrupt vector not moved to boot section");

    a_irq_start_addr: // see (R4) see (R15)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && !PLACEMENT.vector_select_bit && IRQ_SRC.ext_irq_zero
        |=> fetch_q.addr == IRQ_START_OFFSET && fetch_q.vector_no == FIRST_IRQ_VECTOR_NO)
    else $error("first interrupt vector misplaced");

    a_ext_order: // see (R5)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[2:0] == 3'h2
        |=> fetch_q.valid && fetch_q.vector_no == 6'h03)
    else $error("external request one not at vector 3");

    a_watchdog_slot: // see (R6)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[7:0] == 8'h80
        |=> fetch_q.vector_no == 6'h09 ##1 !fetch_q.valid)
    else $error("watchdog not at vector 9 or pulse too long");

    a_timer3_absent: // see (R14)
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.valid && !HAS_TIMER3 |-> fetch_q.vector_no <= LAST_PLAIN_VECTOR_NO)
    else $error("timer 3 vector issued on small member");

    a_vector_stride: // see (R16)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && !PLACEMENT.vector_select_bit
        |=> fetch_q.addr == {10'h000, fetch_q.vector_no - 6'h01, 1'b0}
            && IRQ_TAKEN == (NUM_IRQ'(1) << (fetch_q.vector_no - FIRST_IRQ_VECTOR_NO)))
    else $error("vector address or taken line wrong");

    a_issue_spacing:
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq |=> state_q == ST_ISSUE && !take_irq)
    else $error("request taken while issuing");

    a_pin_change_slot: // see (R6)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[3:0] == 4'h8
        |=> fetch_q.vector_no == 6'h05)
    else $error("pin change 0 not at vector 5");

    a_timer2_slot: // see (R7)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[10:0] == 11'h400
        |=> fetch_q.vector_no == 6'h0C)
    else $error("timer 2 overflow not at vector 12");

    a_timer1_slot: // see (R8)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[11:0] == 12'h800
        |=> fetch_q.vector_no == 6'h0D)
    else $error("timer 1 capture not at vector 13");

    a_timer0_slot: // see (R9)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[17:0] == 18'h2_0000
        |=> fetch_q.vector_no == 6'h13)
    else $error("timer 0 overflow not at vector 19");

    a_spi_slot: // see (R10)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[18:0] == 19'h4_0000
        |=> fetch_q.vector_no == 6'h14)
    else $error("transfer complete not at vector 20");

    a_serial0_slot: // see (R11)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[19:0] == 20'h8_0000
        |=> fetch_q.vector_no == 6'h15)
    else $error("first serial receive not at vector 21");

    a_store_slot: // see (R12)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[26:0] == 27'h400_0000
        |=> fetch_q.vector_no == 6'h1C)
    else $error("store ready not at vector 28");

    a_serial1_slot: // see (R13)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[29:0] == 30'h2000_0000
        |=> fetch_q.vector_no == 6'h1F)
    else $error("second serial transmit not at vector 31");

    a_timer3_slot: // see (R14)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && req_vec[30:0] == 31'h4000_0000
        |=> fetch_q.vector_no == 6'h20)
    else $error("timer 3 capture not at vector 32");

    a_reset_once: // see (R1)
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.valid && fetch_q.is_reset && CE
        |=> !fetch_q.is_reset)
    else $error("reset vector issued twice");

    a_reset_no_taken: // see (R1)
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.is_reset
        |-> taken_q == '0 && fetch_q.vector_no == RESET_VECTOR_NO)
    else $error("reset vector carries an acknowledge");

    a_vsel_start: // see (R4)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && PLACEMENT.vector_select_bit && IRQ_SRC.ext_irq_zero
        |=> fetch_q.addr == 17'($past(PLACEMENT.boot_start) + IRQ_START_OFFSET))
    else $error("moved vectors do not start at boot plus 2");

    a_app_place: // see (R15)
    assert property (@(posedge REF_CLK) disable iff (RST)
        CE && take_irq && !PLACEMENT.vector_select_bit
        |=> fetch_q.addr[16:7] == 10'h000)
    else $error("vector outside flash start area");

    a_idle_quiet:
    assert property (@(posedge REF_CLK) disable iff (RST)
        !fetch_q.valid
        |-> fetch_q.vector_no == 6'h00 && fetch_q.addr == 17'h0_0000 && taken_q == '0)
    else $error("fetch fields not cleared when idle");

    a_taken_onehot:
    assert property (@(posedge REF_CLK) disable iff (RST)
        fetch_q.valid && !fetch_q.is_reset
        |-> $onehot(taken_q))
    else $error("acknowledge not one-hot");

    a_freeze_hold:
    assert property (@(posedge REF_CLK) disable iff (RST)
        !CE
        |=> $stable(fetch_q) && $stable(taken_q) && $stable(state_q))
    else $error("state moved while clock enable low");
endmodule

// ### testbench.sv
/*
 * testbench for the vector map: every fuse and vector-select setting,
 * reset vector read directly, every interrupt vector through the fetch model.
 * assumes a 50 MHz clock and the fetch model on the fetch side.
 */
`timescale 1ns/100ps
module testbench;
    import vector_map_pkg::*;
    logic ref_clk;
    logic rst;
    logic ce;
    logic go;
    placement_type placement;
    irq_src_type irq_src;
    logic vec_req;
    fetch_type fetch;
    logic [33:0] irq_taken;
    logic irq_pending;
    logic small_pending;
    fetch_type last_q;
    logic [33:0] last_taken_q;
    int n_got_q;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    reset_interrupt_vector_map i_dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce),
        .PLACEMENT(placement), .IRQ_SRC(irq_src), .VEC_REQ(vec_req),
        .FETCH(fetch), .IRQ_TAKEN(irq_taken), .IRQ_PENDING(irq_pending));
    reset_interrupt_vector_map #(.HAS_TIMER3(1'b0)) i_small (.REF_CLK(ref_clk), .RST(rst),
        .CE(ce), .PLACEMENT(placement), .IRQ_SRC(irq_src), .VEC_REQ(vec_req),
        .FETCH(), .IRQ_TAKEN(), .IRQ_PENDING(small_pending));
    fetch_model i_fetch (.clk(ref_clk), .go(go), .fetch(fetch), .taken(irq_taken),
        .vec_req(vec_req), .last_q(last_q), .last_taken_q(last_taken_q),
        .n_got_q(n_got_q));

    task automatic check(input string what, input logic [33:0] seen,
        input logic [33:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // reset under one placement, then every source in turn
    task automatic scen_placement(input logic fuse, input logic vsel);
        logic [16:0] base;
        logic [16:0] exp_addr;
        logic [33:0] exp_pend;
        int n;
        base = vsel ? 17'h1_F000 : 17'h0_0000;
        placement = '{boot_reset_fuse: fuse, vector_select_bit: vsel,
            boot_start: 17'h1_F000};
        irq_src = '0;
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk);
        #1;
        exp_addr = fuse ? 17'h0_0000 : 17'h1_F000;
        check("reset fetch", 34'(fetch), {9'h000, 2'b11, 6'h01, exp_addr});
        check("reset pending", 34'({small_pending, irq_pending}), 34'h0);
        for (int i = 0; i < 34; i++)
        begin
            n = n_got_q;
            irq_src = irq_src_type'(34'h0_0000_0001 << i);
            go = ~go;
            for (int t = 0; t < 10 && n_got_q == n; t++)
            begin
                @(posedge ref_clk);
                #1;
            end
            check("vector no", 34'(last_q.vector_no), 34'(i + 2));
            check("vector no", 34'(last_q.vector_no), 34'(i + 2));
            exp_addr = base + 17'(2 * i + 2);
            check("vector addr", 34'(last_q.addr), 34'(exp_addr));
            check("taken", last_taken_q, 34'h0_0000_0001 << i);
            exp_pend = (i < 30) ? 34'h3 : 34'h1;
            check("pending", 34'({small_pending, irq_pending}), exp_pend);
        end
    endtask

    // clock enable low: no take, and a taken answer holds
    task automatic scen_freeze();
        int n;
        n = n_got_q;
        placement = '{boot_reset_fuse: 1'b1, vector_select_bit: 1'b0,
            boot_start: 17'h1_F000};
        irq_src = irq_src_type'(34'h0_0000_0001);
        ce = 1'b0;
        go = ~go;
        repeat (3) @(posedge ref_clk);
        #1;
        check("frozen", 34'({fetch.valid, vec_req}), 34'h1);
        ce = 1'b1;
        @(posedge ref_clk);
        #1;
        ce = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("held fetch", 34'(fetch), {9'h000, 2'b10, 6'h02, 17'h0_0002});
        check("held taken", irq_taken, 34'h0_0000_0001);
        check("answers", 34'(n_got_q - n), 34'h1);
        ce = 1'b1;
        @(posedge ref_clk);
        #1;
        check("released", 34'(fetch), 34'h0);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        go = 1'b0;
        placement = '0;
        irq_src = '0;
        @(posedge ref_clk);
        #1;
        for (int k = 0; k < 4; k++)
            scen_placement(k[1], k[0]);
        scen_freeze();
        conclude();
    end

    // hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            conclude();
        end
    end
endmodule

// ### vector_addr_calc.sv
/*
 * vector address former: placement base plus two words per vector.
 * assumes the boot start address comes from the boot size setting.
 */
`timescale 1ns/100ps
module vector_addr_calc (
    // selection
    input wire logic is_reset,
    input wire logic [5:0] vector_no,
    input wire vector_map_pkg::placement_type place,
    // result
    output logic [16:0] addr
);
    import vector_map_pkg::*;

    wire logic reset_in_boot;
    wire logic irq_in_boot;
    wire logic [16:0] base;

    assign reset_in_boot = (place.boot_reset_fuse == FUSE_PROGRAMMED);
    assign irq_in_boot = place.vector_select_bit;
    assign base = is_reset ? pick_base(reset_in_boot, place.boot_start)
                           : pick_base(irq_in_boot, place.boot_start);
    assign addr = 17'(base + vector_offset(vector_no));
endmodule

// ### vector_map_pkg.sv
/*
 * package for the reset and interrupt vector map: widths, placement
 * constants, source and fetch carriers, and the vector offset function.
 * assumes word addressing of program memory, 17 address bits wide.
 */
package vector_map_pkg;

    // widths and counts
    localparam int ADDR_WIDTH = 17;
    localparam int VEC_NO_WIDTH = 6;
    localparam int NUM_IRQ = 34;
    localparam int TIMER3_FIRST_BIT = 30;

    // vector numbers
    localparam logic [5:0] RESET_VECTOR_NO = 6'h01;
    localparam logic [5:0] FIRST_IRQ_VECTOR_NO = 6'h02;
    localparam logic [5:0] LAST_PLAIN_VECTOR_NO = 6'h1F;

    // placement
    localparam logic [16:0] APP_BASE_ADDR = 17'h0_0000;
    localparam logic [16:0] IRQ_START_OFFSET = 17'h0_0002;
    localparam logic [16:0] VECTOR_STRIDE = 17'h0_0002;
    localparam logic FUSE_PROGRAMMED = 1'h0;

    // values after reset
    localparam logic FUSE_RESET_VALUE = 1'h1;
    localparam logic [16:0] BOOT_RESET_VALUE = 17'h0_0000;

    typedef enum logic [1:0]
    {
        ST_BOOT = 2'h0,
        ST_IDLE = 2'h1,
        ST_ISSUE = 2'h3
    } state_type;

    // one request line per interrupt source, vector 2 last (bit 0)
    typedef struct packed
    {
        logic tmr3_ovf;
        logic tmr3_cmp_b;
        logic tmr3_cmp_a;
        logic tmr3_capture;
        logic ser1_tx_done;
        logic ser1_tx_empty;
        logic ser1_rx_done;
        logic program_store_ready_req;
        logic two_wire_req;
        logic eeprom_ready_req;
        logic conv_done;
        logic comparator;
        logic ser0_tx_done;
        logic ser0_tx_empty;
        logic ser0_rx_done;
        logic spi_done;
        logic tmr0_ovf;
        logic tmr0_cmp_b;
        logic tmr0_cmp_a;
        logic tmr1_ovf;
        logic tmr1_cmp_b;
        logic tmr1_cmp_a;
        logic tmr1_capture;
        logic tmr2_ovf;
        logic tmr2_cmp_b;
        logic tmr2_cmp_a;
        logic watchdog_timeout_req;
        logic pin_change_req_three;
        logic pin_change_req_two;
        logic pin_change_req_one;
        logic pin_change_req_zero;
        logic ext_irq_two;
        logic ext_irq_one;
        logic ext_irq_zero;
    } irq_src_type;

    typedef struct packed
    {
        logic boot_reset_fuse;
        logic vector_select_bit;
        logic [16:0] boot_start;
    } placement_type;

    typedef struct packed
    {
        logic valid;
        logic is_reset;
        logic [5:0] vector_no;
        logic [16:0] addr;
    } fetch_type;

    // two words per vector, vector 1 at offset zero
    function automatic logic [16:0] vector_offset(input logic [5:0] vno);
        logic [16:0] idx;
        idx = 17'(vno) - 17'h0_0001;
        return 17'(idx * VECTOR_STRIDE);
    endfunction

    function automatic logic [16:0] pick_base(input logic in_boot, input logic [16:0] boot);
        return in_boot ? boot : APP_BASE_ADDR;
    endfunction

endpackage
